// file: include/drs_pkg.sv
package drs_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] PWR_DELAY1_MS = 16'd15000;
  localparam logic [15:0] PWR_DELAY2_MS = 16'd30000;
  localparam logic [15:0] PWR_DELAY3_MS = 16'd60000;
  localparam logic [15:0] BRAKE_PAUSE_MS = 16'd50;
  localparam logic [31:0] BRAKE_BACK_INC = 32'h8;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] ADDR_FSCFG = 12'h000;
  localparam logic [11:0] ADDR_SAFEPOS = 12'h004;
  localparam logic [11:0] ADDR_REPTIME = 12'h008;
  localparam logic [11:0] ADDR_GAIN = 12'h00c;
  localparam logic [11:0] ADDR_JOGSTEP = 12'h010;
  localparam logic [11:0] ADDR_JOGWAIT = 12'h014;
  localparam logic [11:0] ADDR_BRKDLY = 12'h018;
  localparam logic [11:0] ADDR_SPDLIM = 12'h01c;
  localparam logic [11:0] ADDR_OPTION = 12'h020;
  localparam logic [11:0] ADDR_STATUS = 12'h024;
  localparam logic [5:0] RST_FSCFG = 6'h00;
  localparam logic [31:0] RST_SAFEPOS = 32'h0;
  localparam logic [15:0] RST_REPTIME = 16'd5000;
  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [31:0] RST_JOGSTEP = 32'h64;
  localparam logic [15:0] RST_JOGWAIT = 16'd500;
  localparam logic [15:0] RST_BRKDLY = 16'd1000;
  localparam logic [15:0] RST_SPDLIM = 16'h0100;
  // ----------------------------------------
  // fields and codes
  // ----------------------------------------
  localparam int FS_CONN_LSB = 0;
  localparam int FS_PWR_LSB = 2;
  localparam int FS_IOPS_LSB = 4;
  localparam logic [1:0] FS_FINISH = 2'h0;
  localparam logic [1:0] FS_ABORT = 2'h1;
  localparam logic [1:0] FS_SAFE = 2'h2;
  localparam logic [1:0] FS_RSVD = 2'h3;
  localparam int CW_JOG_A = 3;
  localparam int CW_JOG_B = 5;
  localparam int GAIN_SHIFT = 4;
  typedef enum logic [2:0] {ST_HOLD, ST_REL_WAIT, ST_REL_BACK, ST_RUN,
    ST_RETRY} drs_state_t;
  typedef enum logic [1:0] {RK_NORMAL, RK_SAFE, RK_STEP, RK_CONT} drs_kind_t;
  typedef enum logic [1:0] {J_IDLE, J_STEP, J_CONT, J_LOCK} drs_jog_t;
endpackage

// file: include/drs_jog_if.sv
`timescale 1ns/10ps
interface drs_jog_if;
  logic stepReq;
  logic contReq;
  logic dirUp;
  logic abortReq;
  logic locked;
  modport unit (output stepReq, contReq, dirUp, abortReq, locked);
  modport sup (input stepReq, contReq, dirUp, abortReq, locked);
endinterface

// file: rtl/drs_jog_unit.sv
`timescale 1ns/10ps
module drs_jog_unit
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // keys and settings
  input wire logic keyUp,
  input wire logic keyDown,
  input wire logic enable,
  input wire logic tick,
  input wire logic [15:0] waitMs,
  // towards supervisor
  drs_jog_if.unit jog
);
  import drs_pkg::*;

  drs_jog_t st;
  logic [15:0] cnt;
  logic both;
  logic held;

  assign both = keyUp & keyDown;
  assign held = jog.dirUp ? keyUp : keyDown;
  assign jog.locked = (st == J_LOCK);

  always_ff @(posedge clk)
  begin
    jog.stepReq <= 1'b0;
    jog.abortReq <= 1'b0;
    if (rst)
    begin
      st <= J_IDLE;
      cnt <= 16'h0;
      jog.contReq <= 1'b0;
      jog.dirUp <= 1'b0;
    end
    else
    begin
      case (st)
        J_IDLE:
        begin
          cnt <= 16'h0;
          if (both)
            st <= J_LOCK;
          else if (enable && (keyUp || keyDown))
          begin
            jog.stepReq <= 1'b1;
            jog.dirUp <= keyUp;
            st <= J_STEP;
          end
        end
        J_STEP:
        begin
          if (both)
          begin
            jog.abortReq <= 1'b1;
            st <= J_LOCK;
          end
          else if (!held)
            st <= J_IDLE;
          else if (cnt >= waitMs)
          begin
            jog.contReq <= 1'b1;
            st <= J_CONT;
          end
          else if (tick)
            cnt <= cnt + 16'h1;
        end
        J_CONT:
        begin
          if (both)
          begin
            jog.abortReq <= 1'b1;
            jog.contReq <= 1'b0;
            st <= J_LOCK;
          end
          else if (!held || !enable)
          begin
            jog.contReq <= 1'b0;
            st <= J_IDLE;
          end
        end
        J_LOCK:
        begin
          jog.contReq <= 1'b0;
          if (!keyUp && !keyDown)
            st <= J_IDLE;
        end
        default:
          st <= J_IDLE;
      endcase
    end
  end

  a_jog_lock: assert property (@(posedge clk) disable iff (rst)
    (st == J_LOCK && (keyUp || keyDown)) |=> !jog.stepReq && !jog.contReq)
    else $error("jog movement while locked out");
endmodule

// file: rtl/drs_run_supervisor.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// - nonzero gain adds drag error times gain, shifted right by 4, to speed, clamped
// - drag monitoring and correction off while braking to target or abort
// - power-up field zero: hold, no automatic movement
// - power-up codes 1,2,3 start safe run after 15, 30, 60 s
// - power-up delay counted from reset, run only after full delay
// - every safe run targets the safe-position register
// - failed safe run retried after repetition time while cause persists
// - connection during power-up safe run aborts it and holds
// - provider bad, code 0: finish run, no new run while bad
// - provider bad, code 1: abort run, no new run while bad
// - after bad-status abort, good status with valid data resumes runs
// - provider bad, code 2: run to safe position
// - good status during that safe run aborts it and holds
// - connection loss codes: 0 finish, 1 abort, 2 safe; no new runs
// - after loss abort, connection with valid data resumes runs
// - connection back during loss safe run aborts it and holds
// - jog keys act when bus down, else only with control bits 3 and 5
// - key press starts one jog step that completes even if the key is released
// - key held past jog wait switches to continuous travel to limit
// - both keys abort jog movement only while the jog key is held; locked until both released
// - snap brake: pause, then back off a few increments, then run
// - snap brake closes configurable delay after run end
module drs_run_supervisor #(
  parameter int TICK_CYCLES = drs_pkg::TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fieldbus state and process data
  input wire logic connUp,
  input wire logic iopsGood,
  input wire logic pdValid,
  input wire logic runReq,
  input wire logic [31:0] runTarget,
  input wire logic [15:0] ctrlWord,
  // jog keys and travel limits
  input wire logic jogKeyUp,
  input wire logic jogKeyDown,
  input wire logic [31:0] lowerLimit,
  input wire logic [31:0] upperLimit,
  // motion core
  input wire logic [31:0] actualPos,
  input wire logic moveBusy,
  input wire logic moveDone,
  input wire logic moveFail,
  output logic moveStart,
  output logic moveStop,
  output logic [31:0] moveTarget,
  // speed path
  input wire logic [15:0] baseSpeed,
  input wire logic [15:0] dragError,
  input wire logic brakingApproach,
  input wire logic brakingAbort,
  output logic [17:0] cmdSpeed,
  output logic dragMonEn,
  // brake
  output logic brakeOpen
);
  import drs_pkg::*;

  logic [5:0] fsCfg;
  logic [31:0] safePos;
  logic [15:0] repTime;
  logic [7:0] gain;
  logic [31:0] jogStep;
  logic [15:0] jogWait;
  logic [15:0] brkDly;
  logic [15:0] spdLim;
  logic brakeFitted;
  drs_state_t state;
  drs_kind_t kind;
  logic [15:0] tmr;
  logic [31:0] pend;
  logic upDir;
  logic [31:0] tickCnt;
  logic tick;
  logic [15:0] pwrCnt;
  logic pwrPending;
  logic pwrSafe;
  logic connPrev;
  logic iopsPrev;
  logic connSafe;
  logic iopsSafe;
  logic [1:0] connCode;
  logic [1:0] iopsCode;
  logic [1:0] pwrCode;
  logic [15:0] pwrDelay;
  logic connLost;
  logic iopsBad;
  logic abortEvt;
  logic safeEvt;
  logic safeWanted;
  logic runAllowed;
  logic jogAllowed;
  logic startReq;
  drs_kind_t startKind;
  logic [31:0] startTarget;
  logic stopNow;
  logic isJog;
  logic [31:0] backTarget;
  logic [17:0] baseExt;
  logic signed [24:0] prod;
  logic signed [24:0] corr;
  logic signed [24:0] limPos;
  logic corrOn;
  logic mapped;
  logic safeReached;

  drs_jog_if jogBus();

  // ----------------------------------------
  // millisecond tick
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || tickCnt == 32'(TICK_CYCLES - 1))
      tickCnt <= 32'h0;
    else
      tickCnt <= tickCnt + 32'h1;
  end
  assign tick = (tickCnt == 32'(TICK_CYCLES - 1));

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  always_comb
  begin
    case (paddr)
      ADDR_FSCFG, ADDR_SAFEPOS, ADDR_REPTIME, ADDR_GAIN, ADDR_JOGSTEP,
      ADDR_JOGWAIT, ADDR_BRKDLY, ADDR_SPDLIM, ADDR_OPTION, ADDR_STATUS:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fsCfg <= RST_FSCFG;
      safePos <= RST_SAFEPOS;
      repTime <= RST_REPTIME;
      gain <= RST_GAIN;
      jogStep <= RST_JOGSTEP;
      jogWait <= RST_JOGWAIT;
      brkDly <= RST_BRKDLY;
      spdLim <= RST_SPDLIM;
      brakeFitted <= 1'b0;
    end
    else if (psel && penable && pwrite)
    begin
      case (paddr)
        ADDR_FSCFG: fsCfg <= pwdata[5:0];
        ADDR_SAFEPOS: safePos <= pwdata;
        ADDR_REPTIME: repTime <= pwdata[15:0];
        ADDR_GAIN: gain <= pwdata[7:0];
        ADDR_JOGSTEP: jogStep <= pwdata;
        ADDR_JOGWAIT: jogWait <= pwdata[15:0];
        ADDR_BRKDLY: brkDly <= pwdata[15:0];
        ADDR_SPDLIM: spdLim <= pwdata[15:0];
        ADDR_OPTION: brakeFitted <= pwdata[0];
        default: ;
      endcase
    end
  end

  // read data latched in the setup phase
  always_ff @(posedge clk)
  begin
    if (rst)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        ADDR_FSCFG: prdata <= {26'h0, fsCfg};
        ADDR_SAFEPOS: prdata <= safePos;
        ADDR_REPTIME: prdata <= {16'h0, repTime};
        ADDR_GAIN: prdata <= {24'h0, gain};
        ADDR_JOGSTEP: prdata <= jogStep;
        ADDR_JOGWAIT: prdata <= {16'h0, jogWait};
        ADDR_BRKDLY: prdata <= {16'h0, brkDly};
        ADDR_SPDLIM: prdata <= {16'h0, spdLim};
        ADDR_OPTION: prdata <= {31'h0, brakeFitted};
        ADDR_STATUS: prdata <= {20'h0, jogBus.locked, pwrPending, connSafe,
          iopsSafe, pwrSafe, brakeOpen, kind, 1'b0, state};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // speed correction
  // ----------------------------------------
  assign corrOn = (gain != 8'h0) && !brakingApproach && !brakingAbort;
  assign dragMonEn = !brakingApproach && !brakingAbort;
  assign baseExt = {{2{baseSpeed[15]}}, baseSpeed};
  assign prod = $signed({{9{dragError[15]}}, dragError}) *
    $signed({17'h0, gain});
  assign limPos = $signed({9'h0, spdLim});

  always_comb
  begin
    corr = prod >>> GAIN_SHIFT;
    if (corr > limPos)
      corr = limPos;
    else if (corr < -limPos)
      corr = -limPos;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cmdSpeed <= 18'h0;
    else if (corrOn)
      cmdSpeed <= baseExt + corr[17:0];
    else
      cmdSpeed <= baseExt;
  end

  // ----------------------------------------
  // fail-safe causes
  // ----------------------------------------
  assign connCode = (fsCfg[FS_CONN_LSB+:2] == FS_RSVD) ? FS_FINISH :
    fsCfg[FS_CONN_LSB+:2];
  assign iopsCode = (fsCfg[FS_IOPS_LSB+:2] == FS_RSVD) ? FS_FINISH :
    fsCfg[FS_IOPS_LSB+:2];
  assign pwrCode = fsCfg[FS_PWR_LSB+:2];
  assign pwrDelay = (pwrCode == 2'h1) ? PWR_DELAY1_MS :
    (pwrCode == 2'h2) ? PWR_DELAY2_MS : PWR_DELAY3_MS;
  assign connLost = connPrev & ~connUp;
  assign iopsBad = iopsPrev & ~iopsGood & connUp;
  assign abortEvt = (connLost && connCode == FS_ABORT) ||
    (iopsBad && iopsCode == FS_ABORT);
  assign safeEvt = (connLost && connCode == FS_SAFE) ||
    (iopsBad && iopsCode == FS_SAFE);
  assign safeWanted = pwrSafe | connSafe | iopsSafe;
  assign runAllowed = connUp & iopsGood & pdValid;
  assign jogAllowed = !connUp ||
    (ctrlWord[CW_JOG_A] && ctrlWord[CW_JOG_B]);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pwrPending <= 1'b1;
      pwrCnt <= 16'h0;
      pwrSafe <= 1'b0;
    end
    else if (connUp)
    begin
      pwrPending <= 1'b0;
      pwrSafe <= 1'b0;
    end
    else if (pwrPending)
    begin
      if (tick && pwrCnt != 16'hffff)
        pwrCnt <= pwrCnt + 16'h1;
      if (pwrCode != 2'h0 && pwrCnt >= pwrDelay)
      begin
        pwrSafe <= 1'b1;
        pwrPending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      connPrev <= 1'b0;
      iopsPrev <= 1'b0;
      connSafe <= 1'b0;
      iopsSafe <= 1'b0;
    end
    else
    begin
      connPrev <= connUp;
      iopsPrev <= iopsGood;
      if (connLost && connCode == FS_SAFE)
        connSafe <= 1'b1;
      else if (connUp)
        connSafe <= 1'b0;
      if (iopsBad && iopsCode == FS_SAFE)
        iopsSafe <= 1'b1;
      else if (iopsGood || !connUp)
        iopsSafe <= 1'b0;
    end
  end

  // ----------------------------------------
  // jog keys
  // ----------------------------------------
  drs_jog_unit jogUnit (
    .clk(clk),
    .rst(rst),
    .keyUp(jogKeyUp),
    .keyDown(jogKeyDown),
    .enable(jogAllowed),
    .tick(tick),
    .waitMs(jogWait),
    .jog(jogBus)
  );

  // ----------------------------------------
  // run selection
  // ----------------------------------------
  always_comb
  begin
    startReq = 1'b1;
    startKind = RK_NORMAL;
    startTarget = runTarget;
    if (safeWanted)
    begin
      startReq = !safeReached;
      startKind = RK_SAFE;
      startTarget = safePos;
    end
    else if (jogAllowed && jogBus.stepReq)
    begin
      startKind = RK_STEP;
      startTarget = jogBus.dirUp ? actualPos + jogStep : actualPos - jogStep;
    end
    else if (jogAllowed && jogBus.contReq)
    begin
      startKind = RK_CONT;
      startTarget = jogBus.dirUp ? upperLimit : lowerLimit;
    end
    else if (!(runReq && runAllowed))
      startReq = 1'b0;
  end

  // arrived safe run is not repeated while its cause persists
  always_ff @(posedge clk)
  begin
    if (rst || !safeWanted)
      safeReached <= 1'b0;
    else if (state == ST_RUN && kind == RK_SAFE && moveDone && !stopNow)
      safeReached <= 1'b1;
  end

  assign isJog = (kind == RK_STEP) || (kind == RK_CONT);
  assign stopNow = ((kind == RK_SAFE) && !safeWanted) ||
    ((kind != RK_SAFE) && (abortEvt || safeEvt)) ||
    (isJog && jogBus.abortReq) || ((kind == RK_CONT) && !jogBus.contReq);
  assign backTarget = upDir ? actualPos - BRAKE_BACK_INC :
    actualPos + BRAKE_BACK_INC;

  // ----------------------------------------
  // run sequencer
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    moveStart <= 1'b0;
    moveStop <= 1'b0;
    if (rst)
    begin
      state <= ST_HOLD;
      kind <= RK_NORMAL;
      tmr <= 16'h0;
      pend <= 32'h0;
      upDir <= 1'b0;
      moveTarget <= 32'h0;
      brakeOpen <= 1'b0;
    end
    else
    begin
      if (tick && tmr != 16'hffff)
        tmr <= tmr + 16'h1;
      case (state)
        ST_HOLD:
        begin
          if (brakeOpen && tmr >= brkDly)
            brakeOpen <= 1'b0;
          if (!moveBusy && startReq)
          begin
            pend <= startTarget;
            kind <= startKind;
            upDir <= $signed(startTarget) > $signed(actualPos);
            tmr <= 16'h0;
            if (brakeFitted && !brakeOpen)
              state <= ST_REL_WAIT;
            else
            begin
              moveTarget <= startTarget;
              moveStart <= 1'b1;
              state <= ST_RUN;
            end
          end
        end
        ST_REL_WAIT:
        begin
          if (tmr >= BRAKE_PAUSE_MS)
          begin
            moveTarget <= backTarget;
            moveStart <= 1'b1;
            brakeOpen <= 1'b1;
            state <= ST_REL_BACK;
          end
        end
        ST_REL_BACK:
        begin
          if (moveDone || moveFail)
          begin
            moveTarget <= pend;
            moveStart <= 1'b1;
            state <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (stopNow)
          begin
            moveStop <= 1'b1;
            state <= ST_HOLD;
            tmr <= 16'h0;
          end
          else if (moveFail && kind == RK_SAFE)
          begin
            state <= ST_RETRY;
            tmr <= 16'h0;
          end
          else if (moveDone || moveFail)
          begin
            state <= ST_HOLD;
            tmr <= 16'h0;
          end
        end
        ST_RETRY:
        begin
          if (!safeWanted || tmr >= repTime)
          begin
            state <= ST_HOLD;
            tmr <= 16'h0;
          end
        end
        default:
          state <= ST_HOLD;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_corr_off: assert property (@(posedge clk) disable iff (rst)
    (gain == 8'h0) |=> cmdSpeed == $past(baseExt))
    else $error("speed changed with zero gain");
  a_brake_suspend: assert property (@(posedge clk) disable iff (rst)
    (brakingApproach || brakingAbort) |-> !dragMonEn ##1
    cmdSpeed == $past(baseExt))
    else $error("correction active while braking");
  a_pwr_hold: assert property (@(posedge clk) disable iff (rst)
    (pwrCode == 2'h0 && !pwrSafe) |=> !pwrSafe)
    else $error("power-up safe run with field zero");
  a_pwr_delay: assert property (@(posedge clk) disable iff (rst)
    $rose(pwrSafe) |-> $past(pwrCnt) >= $past(pwrDelay))
    else $error("power-up safe run before delay");
  a_safe_target: assert property (@(posedge clk) disable iff (rst)
    (moveStart && state == ST_RUN && kind == RK_SAFE) |->
    moveTarget == safePos)
    else $error("safe run to wrong target");
  a_retry_wait: assert property (@(posedge clk) disable iff (rst)
    (state == ST_RETRY && safeWanted && tmr < repTime && !tick) |=>
    state == ST_RETRY)
    else $error("safe run retried early");
  a_safe_exit: assert property (@(posedge clk) disable iff (rst)
    (state == ST_RUN && kind == RK_SAFE && !safeWanted) |=>
    moveStop && state == ST_HOLD)
    else $error("safe run not aborted");
  a_abort_evt: assert property (@(posedge clk) disable iff (rst)
    (state == ST_RUN && kind == RK_NORMAL && abortEvt) |=> moveStop)
    else $error("run not aborted on fault");
  a_no_new_run: assert property (@(posedge clk) disable iff (rst)
    (moveStart && $past(state) == ST_HOLD && kind == RK_NORMAL) |->
    $past(connUp && iopsGood && pdValid))
    else $error("run started while link bad");
  a_jog_gate: assert property (@(posedge clk) disable iff (rst)
    (moveStart && $past(state) == ST_HOLD && isJog) |-> $past(jogAllowed))
    else $error("jog run without enable");
  a_brake_close: assert property (@(posedge clk) disable iff (rst)
    (brakeOpen && state == ST_HOLD && tmr < brkDly) |=> brakeOpen)
    else $error("brake closed before delay");
endmodule

// file: tb/drs_motion_model.sv
`timescale 1ns/10ps
module drs_motion_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // commands from the supervisor
  input wire logic moveStart,
  input wire logic moveStop,
  input wire logic [31:0] moveTarget,
  // failure injection from the bench
  input wire logic failAll,
  // answers of the motion core
  output logic [31:0] actualPos,
  output logic moveBusy,
  output logic moveDone,
  output logic moveFail
);
  int cnt;
  // ----------------------------------------
  // fixed-length move, stop cuts it short
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    moveDone <= 1'b0;
    moveFail <= 1'b0;
    if (rst || moveStop)
    begin
      moveBusy <= 1'b0;
      cnt <= 0;
      if (rst)
        actualPos <= 32'h0;
    end
    else if (moveStart)
    begin
      moveBusy <= 1'b1;
      cnt <= 40;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
    else if (cnt == 1)
    begin
      cnt <= 0;
      moveBusy <= 1'b0;
      if (failAll)
        moveFail <= 1'b1;
      else
      begin
        moveDone <= 1'b1;
        actualPos <= moveTarget;
      end
    end
  end
endmodule

// file: tb/drive_run_supervisor_tb.sv
`timescale 1ns/10ps
module drive_run_supervisor_tb;
  import drs_pkg::*;
  localparam int TK = 2;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, runTarget = 0, lowerLimit = 0;
  logic [31:0] upperLimit = 32'hffff, actualPos, moveTarget, rd;
  logic pready, pslverr, connUp = 0, iopsGood = 1, pdValid = 0;
  logic runReq = 0, jogKeyUp = 0, jogKeyDown = 0, failAll = 0, err, g;
  logic [15:0] ctrlWord = 0, baseSpeed = 16'd100, dragError = 0;
  logic moveBusy, moveDone, moveFail, moveStart, moveStop;
  logic brakingApproach = 0, brakingAbort = 0, dragMonEn, brakeOpen;
  logic [17:0] cmdSpeed;
  int fails = 0, checks_done = 0, up = 0, d;
  always #25 clk = ~clk;
  always @(posedge clk) up <= rst ? 0 : up + 1;
  drs_run_supervisor #(.TICK_CYCLES(TK)) drs_run_supervisor_i (.clk, .rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .connUp, .iopsGood, .pdValid, .runReq, .runTarget, .ctrlWord,
    .jogKeyUp, .jogKeyDown, .lowerLimit, .upperLimit, .actualPos,
    .moveBusy, .moveDone, .moveFail, .moveStart, .moveStop, .moveTarget,
    .baseSpeed, .dragError, .brakingApproach, .brakingAbort, .cmdSpeed,
    .dragMonEn, .brakeOpen);
  drs_motion_model drs_motion_model_i (.clk, .rst, .moveStart, .moveStop,
    .moveTarget, .actualPos, .moveBusy, .moveDone, .moveFail, .failAll);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // look for a start or stop pulse within 60 cycles
  task wait_pulse(input logic stop);
    g = 1'b0;
    for (int i = 0; i < 60 && !g; i++)
    begin
      @(negedge clk);
      g = ((stop ? moveStop : moveStart) === 1'b1);
    end
  endtask
  task go(input logic stop, input logic [31:0] t);
    wait_pulse(stop);
    chk(g, 1'b1);
    if (!stop)
      chk(moveTarget, t);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_REPTIME, 32'h0);
    chk(rd, 32'd5000);
    apb(1'b0, 12'h040, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, ADDR_SAFEPOS, 32'h1234);
    apb(1'b1, ADDR_FSCFG, 32'h04);
    d = PWR_DELAY1_MS * TK;
    wait_pulse(1'b0);
    while (moveStart !== 1'b1 && up < d + 100)
      @(negedge clk);
    chk(up >= d - 1 && up <= d + 6, 1'b1);
    chk(moveTarget, 32'h1234);
    @(posedge clk);
    connUp <= 1'b1;
    go(1'b1, 0);
    apb(1'b1, ADDR_FSCFG, 32'h10);
    runTarget <= 32'h500;
    pdValid <= 1'b1;
    runReq <= 1'b1;
    go(1'b0, 32'h500);
    @(posedge clk);
    iopsGood <= 1'b0;
    go(1'b1, 0);
    @(posedge clk);
    iopsGood <= 1'b1;
    go(1'b0, 32'h500);
    @(posedge clk);
    runReq <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, ADDR_FSCFG, i ? 32'h02 : 32'h20);
      if (i)
        connUp <= 1'b0;
      else
        iopsGood <= 1'b0;
      go(1'b0, 32'h1234);
      @(posedge clk);
      connUp <= 1'b1;
      iopsGood <= 1'b1;
      go(1'b1, 0);
    end
    apb(1'b1, ADDR_FSCFG, 32'h30);
    runReq <= 1'b1;
    go(1'b0, 32'h500);
    @(posedge clk);
    iopsGood <= 1'b0;
    wait_pulse(1'b1);
    chk(g, 1'b0);
    wait_pulse(1'b0);
    chk(g, 1'b0);
    @(posedge clk);
    iopsGood <= 1'b1;
    go(1'b0, 32'h500);
    @(posedge clk);
    runReq <= 1'b0;
    repeat (60) @(posedge clk);
    ctrlWord <= 16'h0;
    jogKeyUp <= 1'b1;
    wait_pulse(1'b0);
    chk(g, 1'b0);
    @(posedge clk);
    jogKeyUp <= 1'b0;
    ctrlWord <= 16'h28;
    repeat (4) @(posedge clk);
    jogKeyUp <= 1'b1;
    go(1'b0, actualPos + RST_JOGSTEP);
    @(posedge clk);
    jogKeyUp <= 1'b0;
    wait_pulse(1'b1);
    chk(g, 1'b0);
    apb(1'b1, ADDR_JOGWAIT, 32'd5);
    jogKeyUp <= 1'b1;
    go(1'b0, actualPos + RST_JOGSTEP);
    go(1'b0, upperLimit);
    @(posedge clk);
    jogKeyDown <= 1'b1;
    go(1'b1, 0);
    @(posedge clk);
    jogKeyDown <= 1'b0;
    wait_pulse(1'b0);
    chk(g, 1'b0);
    @(posedge clk);
    jogKeyUp <= 1'b0;
    apb(1'b1, ADDR_REPTIME, 32'd10);
    apb(1'b1, ADDR_FSCFG, 32'h02);
    failAll <= 1'b1;
    connUp <= 1'b0;
    go(1'b0, 32'h1234);
    d = up;
    repeat (30) @(posedge clk);
    go(1'b0, 32'h1234);
    chk(up - d >= 40 + 10 * TK, 1'b1);
    @(posedge clk);
    failAll <= 1'b0;
    connUp <= 1'b1;
    go(1'b1, 0);
    apb(1'b1, ADDR_OPTION, 32'h1);
    apb(1'b1, ADDR_BRKDLY, 32'd20);
    runReq <= 1'b1;
    @(posedge clk);
    runReq <= 1'b0;
    repeat (80) @(posedge clk);
    chk(brakeOpen, 1'b0);
    go(1'b0, actualPos + BRAKE_BACK_INC);
    chk(brakeOpen, 1'b1);
    go(1'b0, 32'h500);
    repeat (60) @(posedge clk);
    chk(brakeOpen, 1'b1);
    repeat (40) @(posedge clk);
    chk(brakeOpen, 1'b0);
    dragError <= 16'd5;
    apb(1'b1, ADDR_GAIN, 32'h10);
    repeat (2) @(negedge clk);
    chk(cmdSpeed, 18'd105);
    chk(dragMonEn, 1'b1);
    @(posedge clk);
    brakingAbort <= 1'b1;
    repeat (2) @(negedge clk);
    chk(cmdSpeed, 18'd100);
    chk(dragMonEn, 1'b0);
    apb(1'b1, ADDR_GAIN, 32'h0);
    brakingAbort <= 1'b0;
    repeat (2) @(negedge clk);
    chk(cmdSpeed, 18'd100);
    report_and_stop;
  end
  initial
  begin
    #(50 * 40000 * TK);
    fails++;
    report_and_stop;
  end
endmodule
